// ===== rtl/omc_pkg.sv
package omc_pkg;

    // ==========================================================
    // Operating modes
    // ==========================================================
    // Gray order along run, wait, background and trace.
    typedef enum logic [1:0] {
        OMC_RUN = 2'h0,
        OMC_WAIT = 2'h1,
        OMC_BKG = 2'h3,
        OMC_TRACE = 2'h2
    } omc_state_t;

    // ==========================================================
    // Decoded debug commands
    // ==========================================================
    typedef enum logic [2:0] {
        OMC_CMD_MEM = 3'h0,
        OMC_CMD_MEM_STAT = 3'h1,
        OMC_CMD_BDC_REG = 3'h2,
        OMC_CMD_BACKGROUND = 3'h3,
        OMC_CMD_CPU_REG = 3'h4,
        OMC_CMD_TRACE = 3'h5,
        OMC_CMD_GO = 3'h6,
        OMC_CMD_NONE = 3'h7
    } omc_cmd_code_t;

    // One decoded command from the background debug controller.
    typedef struct packed {
        logic valid;
        omc_cmd_code_t code;
    } omc_cmd_t;

    // Events reported by the CPU and the debug logic.
    typedef struct packed {
        logic wait_instr;
        logic sw_brk;
        logic bdc_brk;
        logic dbg_brk;
        logic irq_req;
        logic trace_done;
    } omc_evt_t;

    // Answer to a decoded command.
    typedef struct packed {
        logic ack;
        logic ignored;
        logic mem_en;
    } omc_rsp_t;

    // ==========================================================
    // Constants
    // ==========================================================
    localparam logic [15:0] OMC_RESET_VECTOR = 16'hFFFE;
    localparam logic OMC_BOOT_RST = 1'b1;
    localparam omc_state_t OMC_STATE_RST = OMC_BKG;

endpackage

// ===== rtl/omc_mode_ctrl.sv
`timescale 1ns/100ps
module omc_mode_ctrl (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic background_mode_select_pin_in,
    input omc_pkg::omc_cmd_t cmd_in,
    input omc_pkg::omc_evt_t evt_in,
    output omc_pkg::omc_rsp_t rsp_out,
    output omc_pkg::omc_state_t mode_out,
    output logic status_valid_out,
    output logic status_err_out,
    output logic vector_fetch_out,
    output logic [15:0] vector_addr_out,
    output logic cpu_run_en_out,
    output logic cpu_clk_en_out,
    output logic sys_clk_en_out,
    output logic regulator_full_out,
    output logic clear_ibit_out,
    output logic irq_stack_out,
    output logic cpu_reg_en_out,
    output logic trace_start_out
);
    import omc_pkg::*;

    // ==========================================================
    // Mode pin synchroniser
    // ==========================================================
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic pin_lvl_r;
    logic pin_lvl_nxt;

    // The level only moves once the second and third stages agree.
    always_comb begin
        pin_lvl_nxt = pin_lvl_r;
        if (pin_s2_r == pin_s3_r) begin
            pin_lvl_nxt = pin_s3_r;
        end
    end

    // The chain runs through reset so the strap is valid at release.
    always_ff @(posedge clock_in) begin
        pin_s1_r <= background_mode_select_pin_in;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
        pin_lvl_r <= pin_lvl_nxt;
    end

    // ==========================================================
    // Command classification
    // ==========================================================
    logic cmd_bg;
    logic cmd_nonintr;
    logic cmd_active;
    logic cmd_stat;

    // Split the decoded command into its acceptance classes.
    always_comb begin
        cmd_bg = cmd_in.valid && (cmd_in.code == OMC_CMD_BACKGROUND);
        cmd_stat = cmd_in.valid && (cmd_in.code == OMC_CMD_MEM_STAT);
        cmd_nonintr = 1'b0;
        cmd_active = 1'b0;
        if (cmd_in.valid) begin
            case (cmd_in.code)
                OMC_CMD_MEM,
                OMC_CMD_MEM_STAT,
                OMC_CMD_BDC_REG,
                OMC_CMD_BACKGROUND: begin
                    cmd_nonintr = 1'b1;
                end
                OMC_CMD_CPU_REG,
                OMC_CMD_TRACE,
                OMC_CMD_GO: begin
                    cmd_active = 1'b1;
                end
                default: begin
                    cmd_nonintr = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Mode state machine
    // ==========================================================
    omc_state_t state_r;
    omc_state_t state_nxt;
    logic boot_r;
    logic boot_nxt;
    logic vec_r;
    logic vec_nxt;
    logic clri_r;
    logic clri_nxt;
    logic stack_r;
    logic stack_nxt;
    logic stat_vld_r;
    logic stat_vld_nxt;
    logic stat_err_r;
    logic stat_err_nxt;
    logic trace_r;
    logic trace_nxt;

    // Next mode and the one-cycle side effects of each transition.
    always_comb begin
        state_nxt = state_r;
        boot_nxt = 1'b0;
        vec_nxt = 1'b0;
        clri_nxt = 1'b0;
        stack_nxt = 1'b0;
        trace_nxt = 1'b0;
        stat_vld_nxt = 1'b0;
        stat_err_nxt = stat_err_r;
        if (boot_r) begin
            // The strap decides the first mode right after release.
            if (pin_lvl_r) begin
                state_nxt = OMC_RUN;
                vec_nxt = 1'b1;
            end else begin
                state_nxt = OMC_BKG;
            end
        end else begin
            case (state_r)
                OMC_RUN: begin
                    // Entry into background wins over a wait instruction.
                    if (cmd_bg) begin
                        state_nxt = OMC_BKG;
                    end else if (evt_in.sw_brk) begin
                        state_nxt = OMC_BKG;
                    end else if (evt_in.bdc_brk || evt_in.dbg_brk) begin
                        state_nxt = OMC_BKG;
                    end else if (evt_in.wait_instr) begin
                        state_nxt = OMC_WAIT;
                        clri_nxt = 1'b1;
                    end
                end
                OMC_WAIT: begin
                    // A debugger wake beats a pending interrupt.
                    if (cmd_bg) begin
                        state_nxt = OMC_BKG;
                    end else if (evt_in.irq_req) begin
                        state_nxt = OMC_RUN;
                        stack_nxt = 1'b1;
                    end
                end
                OMC_BKG: begin
                    // Only debugger commands move the CPU from here.
                    if (cmd_in.valid && cmd_in.code == OMC_CMD_GO) begin
                        state_nxt = OMC_RUN;
                    end else if (cmd_in.valid && cmd_in.code == OMC_CMD_TRACE) begin
                        state_nxt = OMC_TRACE;
                        trace_nxt = 1'b1;
                    end
                end
                OMC_TRACE: begin
                    // Any stop of the single step lands in background.
                    if (evt_in.trace_done || cmd_bg || evt_in.sw_brk ||
                        evt_in.bdc_brk || evt_in.dbg_brk) begin
                        state_nxt = OMC_BKG;
                    end
                end
                default: begin
                    state_nxt = OMC_BKG;
                end
            endcase
        end
        // Status commands report wait as an error; in wait they touch no memory.
        if (cmd_stat && !boot_r) begin
            stat_vld_nxt = 1'b1;
            stat_err_nxt = (state_r == OMC_WAIT);
        end
    end

    // Registers of the mode machine; reset parks in background.
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_r <= OMC_STATE_RST;
            boot_r <= OMC_BOOT_RST;
            vec_r <= 1'b0;
            clri_r <= 1'b0;
            stack_r <= 1'b0;
            trace_r <= 1'b0;
            stat_vld_r <= 1'b0;
            stat_err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            boot_r <= boot_nxt;
            vec_r <= vec_nxt;
            clri_r <= clri_nxt;
            stack_r <= stack_nxt;
            trace_r <= trace_nxt;
            stat_vld_r <= stat_vld_nxt;
            stat_err_r <= stat_err_nxt;
        end
    end

    // ==========================================================
    // Command answer
    // ==========================================================
    // Acceptance depends only on the present mode, so it is immediate.
    always_comb begin
        rsp_out = '0;
        if (cmd_in.valid && !boot_r) begin
            case (state_r)
                OMC_RUN,
                OMC_TRACE: begin
                    rsp_out.ack = cmd_nonintr;
                    rsp_out.ignored = cmd_active;
                end
                OMC_BKG: begin
                    rsp_out.ack = cmd_nonintr || cmd_active;
                end
                OMC_WAIT: begin
                    rsp_out.ack = cmd_bg || cmd_stat;
                    rsp_out.ignored = !(cmd_bg || cmd_stat);
                end
                default: begin
                    rsp_out.ignored = 1'b1;
                end
            endcase
            // Memory is reached only outside wait.
            rsp_out.mem_en = rsp_out.ack && (state_r != OMC_WAIT) &&
                (cmd_in.code == OMC_CMD_MEM || cmd_in.code == OMC_CMD_MEM_STAT);
        end else if (cmd_in.valid) begin
            rsp_out.ignored = 1'b1;
        end
    end

    // ==========================================================
    // CPU controls
    // ==========================================================
    // The CPU fetches only in run or during a single traced step.
    assign cpu_run_en_out = !boot_r &&
        (state_r == OMC_RUN || state_r == OMC_TRACE);
    assign cpu_clk_en_out = (state_r != OMC_WAIT);
    // Stop modes are not handled here, so the system clock and regulation stay on.
    assign sys_clk_en_out = 1'b1;
    assign regulator_full_out = 1'b1;
    // Register access to the CPU is gated to background mode.
    assign cpu_reg_en_out = cmd_in.valid && !boot_r &&
        cmd_in.code == OMC_CMD_CPU_REG && state_r == OMC_BKG;
    assign mode_out = state_r;
    assign vector_fetch_out = vec_r;
    assign vector_addr_out = OMC_RESET_VECTOR;
    assign clear_ibit_out = clri_r;
    assign irq_stack_out = stack_r;
    assign trace_start_out = trace_r;
    assign status_valid_out = stat_vld_r;
    assign status_err_out = stat_err_r;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking omc_cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    a_boot_run_sel: assert property (
        boot_r && pin_lvl_r |=> state_r == OMC_RUN && vector_fetch_out)
        else $error("High strap did not boot into run.");

    a_vector_fetch: assert property (
        vector_fetch_out |-> state_r == OMC_RUN && vector_addr_out == 16'hFFFE)
        else $error("Vector fetch outside run or at wrong address.");

    a_boot_bkg_sel: assert property (
        boot_r && !pin_lvl_r |=> state_r == OMC_BKG && !cpu_run_en_out)
        else $error("Low strap did not boot into background.");

    a_bg_cmd_entry: assert property (
        !boot_r && state_r == OMC_RUN && cmd_bg |-> rsp_out.ack ##1 state_r == OMC_BKG)
        else $error("BACKGROUND command did not enter background.");

    a_sw_brk_entry: assert property (
        !boot_r && state_r == OMC_RUN && evt_in.sw_brk |=> state_r == OMC_BKG)
        else $error("Software breakpoint did not enter background.");

    a_hw_brk_entry: assert property (
        !boot_r && state_r == OMC_RUN && (evt_in.bdc_brk || evt_in.dbg_brk)
        |=> state_r == OMC_BKG)
        else $error("Breakpoint did not enter background.");

    a_bkg_suspend: assert property (
        state_r == OMC_BKG |-> !cpu_run_en_out)
        else $error("CPU runs in background mode.");

    a_nonintr_ack: assert property (
        !boot_r && cmd_nonintr && (state_r == OMC_RUN || state_r == OMC_BKG)
        |-> rsp_out.ack && !rsp_out.ignored)
        else $error("Non-intrusive command refused.");

    a_go_resume: assert property (
        !boot_r && state_r == OMC_BKG && cmd_in.valid && cmd_in.code == OMC_CMD_GO
        |=> state_r == OMC_RUN && cpu_run_en_out)
        else $error("GO did not resume the program.");

    a_active_refused: assert property (
        cmd_active && state_r != OMC_BKG |-> !rsp_out.ack && !cpu_reg_en_out)
        else $error("Background-only command accepted outside background.");

    a_wait_clk_off: assert property (
        state_r == OMC_WAIT |-> !cpu_clk_en_out && !cpu_run_en_out)
        else $error("CPU clock runs in wait.");

    a_wait_sys_on: assert property (
        state_r == OMC_WAIT |-> sys_clk_en_out && regulator_full_out)
        else $error("System clock or regulation dropped in wait.");

    a_wait_ibit: assert property (
        state_r == OMC_WAIT && $past(state_r) != OMC_WAIT |-> clear_ibit_out)
        else $error("Mask bit not cleared on wait entry.");

    a_irq_wake: assert property (
        state_r == OMC_WAIT && evt_in.irq_req && !cmd_bg
        |=> state_r == OMC_RUN && irq_stack_out)
        else $error("Interrupt did not wake into stacking.");

    a_wait_filter: assert property (
        state_r == OMC_WAIT && cmd_in.valid |-> rsp_out.ack == (cmd_bg || cmd_stat))
        else $error("Wrong command set accepted in wait.");

    a_wait_stat_err: assert property (
        state_r == OMC_WAIT && cmd_stat |-> !rsp_out.mem_en ##1
        status_valid_out && status_err_out)
        else $error("Status command in wait did not report error.");

    a_wait_bg_wake: assert property (
        state_r == OMC_WAIT && cmd_bg |=> state_r == OMC_BKG)
        else $error("BACKGROUND did not wake wait into background.");

endmodule

// ===== sim/omc_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Debug host on the single-wire background pin
// ==========================================================
module omc_host_model (
    input wire logic clock_in,
    input omc_pkg::omc_rsp_t rsp_in,
    output omc_pkg::omc_cmd_t cmd_out
);
    import omc_pkg::*;

    int n_ignored = 0;

    // Nothing is on the wire until the first command.
    initial cmd_out = '{valid: 1'b0, code: OMC_CMD_NONE};

    // A command is a one-cycle pulse, raised just after an edge.
    // A withdrawn code is inverted so a stale value is never mistaken for a new one.
    task automatic issue(input logic v, input omc_cmd_code_t c);
        cmd_out.valid = v;
        cmd_out.code = v ? c : omc_cmd_code_t'(~cmd_out.code);
    endtask

    // Refused commands are counted; the host does not send them again.
    always @(posedge clock_in) begin
        if (cmd_out.valid && rsp_in.ignored) begin
            n_ignored++;
        end
    end
endmodule

// ===== sim/test_operating_mode_control.sv
`timescale 1ns/100ps
module test_operating_mode_control;
    import omc_pkg::*;

    // ==========================================================
    // Stimulus, design and partner
    // ==========================================================
    localparam logic [5:0] EW = 6'h20;
    localparam logic [5:0] EIRQ = 6'h02;
    localparam logic [5:0] ETD = 6'h01;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic pin = 1'b1;
    omc_evt_t evt = '0;
    omc_cmd_t cmd;
    omc_rsp_t rsp;
    omc_state_t mode;
    logic sv_o, se_o, vf_o, run_o, clk_o, sys_o, reg_o, ci_o, is_o, cr_o, ts_o;
    logic [15:0] va_o;
    logic [5:0] brks [3] = '{6'h10, 6'h08, 6'h04};
    int err_count = 0;
    int n_tests = 0;
    int m = 3;
    int serr = 0;
    int n_ign = 0;
    int i;

    // The 50 ns period gives the 20 MHz system clock.
    always #25 clock_in = ~clock_in;

    omc_host_model omc_host_model_i (.clock_in(clock_in), .rsp_in(rsp), .cmd_out(cmd));

    omc_mode_ctrl omc_mode_ctrl_i (
        .clock_in(clock_in), .reset_n_in(reset_n_in),
        .background_mode_select_pin_in(pin), .cmd_in(cmd), .evt_in(evt),
        .rsp_out(rsp), .mode_out(mode), .status_valid_out(sv_o), .status_err_out(se_o),
        .vector_fetch_out(vf_o), .vector_addr_out(va_o), .cpu_run_en_out(run_o),
        .cpu_clk_en_out(clk_o), .sys_clk_en_out(sys_o), .regulator_full_out(reg_o),
        .clear_ibit_out(ci_o), .irq_stack_out(is_o), .cpu_reg_en_out(cr_o),
        .trace_start_out(ts_o)
    );

    // ==========================================================
    // Checking
    // ==========================================================
    task automatic fail(input string msg);
        err_count++;
        $display("[ERR] %0t ns: %s", $time, msg);
    endtask

    // The answer is combinational, so it is looked at while the command stands.
    task automatic chk_rsp(input logic [3:0] exp);
        n_tests++;
        if ({rsp, cr_o} !== exp) begin
            fail($sformatf("response %b, expected %b", {rsp, cr_o}, exp));
        end
    endtask

    // The host's own tally of refused commands against the reference count.
    task automatic chk_ign();
        n_tests++;
        if (omc_host_model_i.n_ignored != n_ign) begin
            fail($sformatf("host saw %0d refusals, expected %0d",
                omc_host_model_i.n_ignored, n_ign));
        end
    endtask

    // Mode and every side pulse, one cycle after their cause.
    task automatic chk_state(input logic sv, ci, irq_s, ts, vf);
        logic [27:0] exp;
        exp = {m[1:0], sv, serr[0], ci, irq_s, ts, vf, m == 0 || m == 2, m != 1, 2'h3, 16'hFFFE};
        n_tests++;
        if ({mode, sv_o, se_o, ci_o, is_o, ts_o, vf_o, run_o, clk_o, sys_o, reg_o, va_o} !== exp) begin
            fail($sformatf("state wrong, expected %h", exp));
        end
    endtask

    // ==========================================================
    // Reference model and drivers
    // ==========================================================
    // Reset long enough for the strap synchroniser, then the boot cycle.
    task automatic do_reset(input logic strap);
        reset_n_in = 1'b0;
        pin = strap;
        evt = '0;
        omc_host_model_i.issue(1'b0, OMC_CMD_NONE);
        repeat (6) @(posedge clock_in);
        #1 reset_n_in = 1'b1;
        // The first edge after release already applies the strap decision.
        @(posedge clock_in);
        #1 m = strap ? 0 : 3;
        serr = 0;
        chk_state(1'b0, 1'b0, 1'b0, 1'b0, strap);
    endtask

    // One cycle of traffic; the model works out acceptance and the next mode.
    task automatic step(input logic v, input logic [2:0] c, input logic [5:0] e);
        int ok, nm, sv, ci, irq_s, ts;
        omc_host_model_i.issue(v, omc_cmd_code_t'(c));
        evt = omc_evt_t'(e);
        ok = v && (m == 3 || (m == 1 ? (c == 1 || c == 3) : c < 4));
        if (v && !ok) begin
            n_ign++;
        end
        #20;
        chk_rsp({ok[0], v && !ok, ok && c < 2 && m != 1, ok && c == 4});
        nm = m;
        sv = 0;
        ci = 0;
        irq_s = 0;
        ts = 0;
        if (ok && c == 1) begin
            sv = 1;
            serr = (m == 1);
        end
        if (m == 0 || m == 2) begin
            if ((ok && c == 3) || e[4] || e[3] || e[2] || (m == 2 && e[0])) begin
                nm = 3;
            end else if (m == 0 && e[5]) begin
                nm = 1;
                ci = 1;
            end
        end else if (m == 1) begin
            if (ok && c == 3) begin
                nm = 3;
            end else if (e[1]) begin
                nm = 0;
                irq_s = 1;
            end
        end else if (ok && c == 6) begin
            nm = 0;
        end else if (ok && c == 5) begin
            nm = 2;
            ts = 1;
        end
        @(posedge clock_in);
        #1 m = nm;
        chk_state(sv[0], ci[0], irq_s[0], ts[0], 1'b0);
    endtask

    // Every command code but NONE once, BACKGROUND last so the mode leaves at the end.
    task automatic sweep();
        for (int k = 0; k < 7; k++) begin
            step(1'b1, 3'((k + 4) % 7), 6'h00);
        end
    endtask

    task automatic end_test(input string name);
        $display("%s finished, mismatches so far %0d", name, err_count);
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        void'($urandom(34));
        do_reset(1'b1);
        sweep();
        sweep();
        step(1'b1, OMC_CMD_GO, 6'h00);
        step(1'b0, 3'h0, EW);
        sweep();
        step(1'b1, OMC_CMD_GO, 6'h00);
        step(1'b0, 3'h0, EW);
        step(1'b0, 3'h0, EIRQ);
        step(1'b1, OMC_CMD_BACKGROUND, EW);
        step(1'b1, OMC_CMD_GO, 6'h00);
        for (i = 0; i < 3; i++) begin
            step(1'b0, 3'h0, brks[i]);
            step(1'b1, OMC_CMD_GO, 6'h00);
        end
        step(1'b1, OMC_CMD_BACKGROUND, 6'h00);
        step(1'b1, OMC_CMD_TRACE, 6'h00);
        step(1'b0, 3'h0, ETD);
        end_test("directed modes");
        do_reset(1'b0);
        step(1'b1, OMC_CMD_CPU_REG, 6'h00);
        end_test("strap low");
        // Random traffic; the strap wanders too, which must not matter outside reset.
        for (i = 0; i < 400; i++) begin
            pin = 1'($urandom);
            step(1'($urandom % 3 != 0), 3'($urandom % 7), 6'(6'h01 << ($urandom % 12)));
        end
        chk_ign();
        end_test("random");
        conclude();
    end

    // A hung run is cut short and counted as a mismatch.
    initial begin
        #2000000;
        fail("run did not finish");
        conclude();
    end
endmodule
